// ### src/spcfg_pkg.sv
/*
 * constants for the serial port configuration register bank:
 * offsets, field positions, reset values and soft reset states.
 * assumes nothing of its surroundings.
 */
package spcfg_pkg;
    // register offsets within the serial port address space
    localparam logic [11:0] OFS_PORT_CFG = 12'h000;
    localparam logic [11:0] OFS_VARIANT_ID = 12'h003;
    localparam logic [11:0] OFS_READBACK_SEL = 12'h004;
    localparam logic [11:0] OFS_TAG_LOW = 12'h005;
    localparam logic [11:0] OFS_TAG_HIGH = 12'h006;

    // port configuration and readback select field positions
    localparam int POS_FOUR_WIRE = 7;
    localparam int POS_LSB_FIRST = 6;
    localparam int POS_SOFT_RESET = 5;
    localparam int POS_UNUSED4 = 4;
    localparam int POS_READ_ACTIVE = 0;

    // reset values
    localparam logic RST_FOUR_WIRE = 1'b0;
    localparam logic RST_LSB_FIRST = 1'b0;
    localparam logic RST_READ_ACTIVE = 1'b0;
    localparam logic [7:0] RST_TAG = 8'h00;
    localparam logic [7:0] RST_VARIANT_ID = 8'h5A; // arbitrary value
    localparam logic [7:0] READ_ZERO = 8'h00;

    // soft reset sequencing
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RELOAD = 2'b01
    } reload_state_e;
endpackage

// ### src/pin_sync3.sv
/*
 * three flip-flop synchroniser for a pin level.
 * assumes the pin is asynchronous to clk; the output follows only
 * when the second and third stages agree.
 */
`timescale 1ns/1ns
module pin_sync3 (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pin and synchronised level
    input wire logic pin,
    output logic level
);
    logic s1_reg, s2_reg, s3_reg, level_reg;
    logic level_next;

    // accept a change only once two late stages agree
    always_comb begin
        level_next = level_reg;
        if (s2_reg == s3_reg) begin
            level_next = s3_reg;
        end
    end

    // first stage feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            level_reg <= 1'b0;
        end else begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            level_reg <= level_next;
        end
    end

    assign level = level_reg;
endmodule

// ### src/spcfg_regs.sv
/*
 * serial port configuration register bank: transfer mode, bit order,
 * self-clearing soft reset, variant identifier, readback source select
 * and a 16-bit user version tag with buffered and active copies.
 * assumes a serial controller on clk that issues one-cycle byte
 * read/write strobes and honours the order and mode outputs.
 */
`timescale 1ns/1ns
module spcfg_regs
    import spcfg_pkg::*;
#(
    parameter logic [7:0] VARIANT_ID = RST_VARIANT_ID
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // byte access from the serial controller
    input wire logic [11:0] acc_addr,
    input wire logic [7:0] acc_wdata,
    input wire logic acc_wr,
    input wire logic acc_rd,
    output logic [7:0] acc_rdata,
    output logic acc_ack,
    // mode pins and transfer commit
    input wire logic i2c_mode_pin,
    input wire logic config_load_pin,
    input wire logic io_update,
    // nonvolatile image presented for reload
    input wire logic [7:0] nv_port_cfg,
    input wire logic [7:0] nv_readback_sel,
    input wire logic [7:0] nv_tag_low,
    input wire logic [7:0] nv_tag_high,
    // read data direction from the serial controller
    input wire logic host_reading,
    // steering to the serial controller
    output logic four_wire_select,
    output logic lsb_first,
    output logic addr_increment,
    output logic read_from_active,
    output logic bidir_read_oe,
    output logic serial_read_out_pin_oe,
    // soft reset strobes
    output logic reload_from_nv,
    output logic reload_from_defaults,
    // active user tag, for saving to storage
    output logic [15:0] user_tag
);
    logic i2c_mode, load_from_nv;
    reload_state_e state_reg, state_next;
    logic four_wire_reg, four_wire_next;
    logic lsb_first_reg, lsb_first_next;
    logic read_active_reg, read_active_next;
    logic [7:0] tag_lo_buf_reg, tag_lo_buf_next, tag_hi_buf_reg, tag_hi_buf_next;
    logic [7:0] tag_lo_act_reg, tag_lo_act_next, tag_hi_act_reg, tag_hi_act_next;
    logic [7:0] rdata_reg, rdata_next;
    logic ack_reg, ack_next;
    logic nv_strobe_reg, nv_strobe_next, def_strobe_reg, def_strobe_next;
    logic [7:0] cfg_view;
    logic wr_cfg;

    // pins arrive unsynchronised
    pin_sync3 u_sync_i2c (
        .clk(clk),
        .rst_n(rst_n),
        .pin(i2c_mode_pin),
        .level(i2c_mode)
    );
    pin_sync3 u_sync_load (
        .clk(clk),
        .rst_n(rst_n),
        .pin(config_load_pin),
        .level(load_from_nv)
    );

    // writes are held off while a reload is in progress
    assign wr_cfg = acc_wr && (acc_addr == OFS_PORT_CFG) && (state_reg == ST_IDLE);

    // port config readback: upper nibble mirrored into lower
    always_comb begin
        cfg_view = READ_ZERO;
        cfg_view[POS_FOUR_WIRE] = four_wire_reg && !i2c_mode;
        cfg_view[POS_LSB_FIRST] = lsb_first_reg && !i2c_mode;
        cfg_view[POS_SOFT_RESET] = (state_reg == ST_RELOAD);
        cfg_view[POS_UNUSED4] = 1'b0;
        cfg_view[3:0] = {cfg_view[4], cfg_view[5], cfg_view[6], cfg_view[7]};
    end

    // soft reset sequencing and register next values
    always_comb begin
        state_next = state_reg;
        four_wire_next = four_wire_reg;
        lsb_first_next = lsb_first_reg;
        read_active_next = read_active_reg;
        tag_lo_buf_next = tag_lo_buf_reg;
        tag_hi_buf_next = tag_hi_buf_reg;
        tag_lo_act_next = tag_lo_act_reg;
        tag_hi_act_next = tag_hi_act_reg;
        nv_strobe_next = 1'b0;
        def_strobe_next = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (wr_cfg) begin
                    if (!i2c_mode) begin
                        four_wire_next = acc_wdata[POS_FOUR_WIRE];
                        lsb_first_next = acc_wdata[POS_LSB_FIRST];
                    end
                    if (acc_wdata[POS_SOFT_RESET]) begin
                        state_next = ST_RELOAD;
                    end
                end
                if (acc_wr && acc_addr == OFS_READBACK_SEL) begin
                    read_active_next = acc_wdata[POS_READ_ACTIVE];
                end
                if (acc_wr && acc_addr == OFS_TAG_LOW) begin
                    tag_lo_buf_next = acc_wdata;
                end
                if (acc_wr && acc_addr == OFS_TAG_HIGH) begin
                    tag_hi_buf_next = acc_wdata;
                end
                // buffered copies go live on commit
                if (io_update) begin
                    tag_lo_act_next = tag_lo_buf_next;
                    tag_hi_act_next = tag_hi_buf_next;
                end
            end
            ST_RELOAD: begin
                state_next = ST_IDLE;
                if (load_from_nv) begin
                    nv_strobe_next = 1'b1;
                    four_wire_next = nv_port_cfg[POS_FOUR_WIRE];
                    lsb_first_next = nv_port_cfg[POS_LSB_FIRST];
                    read_active_next = nv_readback_sel[POS_READ_ACTIVE];
                    tag_lo_buf_next = nv_tag_low;
                    tag_hi_buf_next = nv_tag_high;
                    tag_lo_act_next = nv_tag_low;
                    tag_hi_act_next = nv_tag_high;
                end else begin
                    def_strobe_next = 1'b1;
                    four_wire_next = RST_FOUR_WIRE;
                    lsb_first_next = RST_LSB_FIRST;
                    read_active_next = RST_READ_ACTIVE;
                    tag_lo_buf_next = RST_TAG;
                    tag_hi_buf_next = RST_TAG;
                    tag_lo_act_next = RST_TAG;
                    tag_hi_act_next = RST_TAG;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // read data mux, registered one cycle after the strobe
    always_comb begin
        rdata_next = rdata_reg;
        ack_next = acc_rd || acc_wr;
        if (acc_rd) begin
            case (acc_addr)
                OFS_PORT_CFG: rdata_next = cfg_view;
                OFS_VARIANT_ID: rdata_next = VARIANT_ID;
                OFS_READBACK_SEL: rdata_next = {7'h00, read_active_reg};
                OFS_TAG_LOW: rdata_next = read_active_reg ? tag_lo_act_reg : tag_lo_buf_reg;
                OFS_TAG_HIGH: rdata_next = read_active_reg ? tag_hi_act_reg : tag_hi_buf_reg;
                default: rdata_next = READ_ZERO;
            endcase
        end
    end

    // state registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            four_wire_reg <= RST_FOUR_WIRE;
            lsb_first_reg <= RST_LSB_FIRST;
            read_active_reg <= RST_READ_ACTIVE;
            tag_lo_buf_reg <= RST_TAG;
            tag_hi_buf_reg <= RST_TAG;
            tag_lo_act_reg <= RST_TAG;
            tag_hi_act_reg <= RST_TAG;
            rdata_reg <= READ_ZERO;
            ack_reg <= 1'b0;
            nv_strobe_reg <= 1'b0;
            def_strobe_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            four_wire_reg <= four_wire_next;
            lsb_first_reg <= lsb_first_next;
            read_active_reg <= read_active_next;
            tag_lo_buf_reg <= tag_lo_buf_next;
            tag_hi_buf_reg <= tag_hi_buf_next;
            tag_lo_act_reg <= tag_lo_act_next;
            tag_hi_act_reg <= tag_hi_act_next;
            rdata_reg <= rdata_next;
            ack_reg <= ack_next;
            nv_strobe_reg <= nv_strobe_next;
            def_strobe_reg <= def_strobe_next;
        end
    end

    assign lsb_first = lsb_first_reg && !i2c_mode;
    assign addr_increment = lsb_first;
    assign four_wire_select = four_wire_reg && !i2c_mode;
    assign serial_read_out_pin_oe = host_reading && four_wire_select;
    assign bidir_read_oe = host_reading && !four_wire_select;
    assign read_from_active = read_active_reg;
    assign reload_from_nv = nv_strobe_reg;
    assign reload_from_defaults = def_strobe_reg;
    assign user_tag = {tag_hi_act_reg, tag_lo_act_reg};
    assign acc_rdata = rdata_reg;
    assign acc_ack = ack_reg;

    sequence seq_reset_write;
        acc_wr && acc_addr == OFS_PORT_CFG && acc_wdata[POS_SOFT_RESET] && state_reg == ST_IDLE;
    endsequence
    sequence seq_reload_done;
        state_reg == ST_RELOAD ##1 state_reg == ST_IDLE;
    endsequence

    AST_READ_PIN_FLOAT: assert property (@(posedge clk) disable iff (!rst_n)
        !four_wire_select |-> !serial_read_out_pin_oe)
        else $error("read pin driven in three-wire mode");
    AST_FOUR_WIRE_READ: assert property (@(posedge clk) disable iff (!rst_n)
        host_reading && four_wire_select |-> serial_read_out_pin_oe && !bidir_read_oe)
        else $error("four-wire read not on read pin");
    AST_ORDER_LINK: assert property (@(posedge clk) disable iff (!rst_n)
        wr_cfg && !i2c_mode |=> i2c_mode
        || (lsb_first == $past(acc_wdata[POS_LSB_FIRST]) && addr_increment == lsb_first))
        else $error("address direction disagrees with bit order");
    AST_I2C_IGNORE: assert property (@(posedge clk) disable iff (!rst_n)
        i2c_mode |-> !lsb_first && !four_wire_select)
        else $error("order bits active in I2C mode");
    AST_SELF_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
        seq_reset_write |=> seq_reload_done ##0 (reload_from_nv || reload_from_defaults))
        else $error("soft reset did not clear itself");
    AST_RELOAD_SOURCE: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == ST_RELOAD && !load_from_nv |=> reload_from_defaults && user_tag == 16'h0000)
        else $error("default reload wrong");
    AST_VARIANT_READ: assert property (@(posedge clk) disable iff (!rst_n)
        acc_rd && acc_addr == OFS_VARIANT_ID |=> acc_rdata == VARIANT_ID && acc_ack)
        else $error("variant identifier read wrong");
    AST_READBACK_SRC: assert property (@(posedge clk) disable iff (!rst_n)
        acc_rd && acc_addr == OFS_TAG_LOW && !read_active_reg
        |=> acc_rdata == $past(tag_lo_buf_reg))
        else $error("buffered readback wrong");
    AST_UNUSED_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
        acc_rd && acc_addr == OFS_READBACK_SEL |=> acc_rdata[7:1] == 7'h00)
        else $error("unused bits not zero");
    AST_TAG_COMMIT: assert property (@(posedge clk) disable iff (!rst_n)
        io_update && state_reg == ST_IDLE && !acc_wr
        |=> user_tag == {$past(tag_hi_buf_reg), $past(tag_lo_buf_reg)})
        else $error("tag not committed on update");
endmodule

// ### tb/host_model.sv
/*
 * host serial controller model: issues one-cycle byte read and write
 * strobes to the configuration register bank.
 * assumes the bank answers one cycle after each strobe.
 */
`timescale 1ns/1ns
module host_model
    import spcfg_pkg::*;
(
    // clock
    input wire logic clk,
    // byte access to the bank
    output logic [11:0] acc_addr,
    output logic [7:0] acc_wdata,
    output logic acc_wr,
    output logic acc_rd,
    input wire logic [7:0] acc_rdata,
    input wire logic acc_ack
);
    // idle bus at time zero
    initial begin
        acc_addr = 12'hFFF;
        acc_wdata = 8'hFF;
        acc_wr = 1'b0;
        acc_rd = 1'b0;
    end

    // one write strobe, launched on the falling edge
    task automatic write_byte(input logic [11:0] addr, input logic [7:0] data);
        logic [7:0] b;
        b = data;
        if (addr == OFS_PORT_CFG) begin
            b[3:0] = {data[4], data[5], data[6], data[7]};
        end
        @(negedge clk);
        acc_addr = addr;
        acc_wdata = b;
        acc_wr = 1'b1;
        @(negedge clk);
        acc_wr = 1'b0;
        // released lines show the inverse, so a stale copy is never trusted
        acc_addr = ~addr;
        acc_wdata = ~b;
    endtask

    // one read strobe; data and ack taken in the answer cycle
    task automatic read_byte(input logic [11:0] addr, output logic [7:0] data,
                             output logic ack);
        @(negedge clk);
        acc_addr = addr;
        acc_rd = 1'b1;
        @(negedge clk);
        acc_rd = 1'b0;
        acc_addr = ~addr;
        data = acc_rdata;
        ack = acc_ack;
    endtask
endmodule

// ### tb/tb.sv
/*
 * self-checking bench for the serial port configuration bank.
 * assumes the host model drives the byte port; pins driven here.
 */
`timescale 1ns/1ns
module tb;
    import spcfg_pkg::*;
    localparam logic [7:0] VID = 8'h3C; // arbitrary value
    // clock, reset and pins
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic i2c_mode_pin = 1'b0;
    logic config_load_pin = 1'b0;
    logic io_update = 1'b0;
    logic host_reading = 1'b0;
    // byte port
    logic [11:0] acc_addr;
    logic [7:0] acc_wdata, acc_rdata;
    logic acc_wr, acc_rd, acc_ack;
    // steering and strobes
    logic four_wire_select, lsb_first, addr_increment, read_from_active;
    logic bidir_read_oe, serial_read_out_pin_oe, reload_from_nv, reload_from_defaults;
    logic [15:0] user_tag;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;

    // 50 MHz clock
    always #10 clk = ~clk;

    host_model hm (.clk(clk), .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_wr(acc_wr),
        .acc_rd(acc_rd), .acc_rdata(acc_rdata), .acc_ack(acc_ack));

    spcfg_regs #(.VARIANT_ID(VID)) DUT (.clk(clk), .rst_n(rst_n), .acc_addr(acc_addr),
        .acc_wdata(acc_wdata), .acc_wr(acc_wr), .acc_rd(acc_rd), .acc_rdata(acc_rdata),
        .acc_ack(acc_ack), .i2c_mode_pin(i2c_mode_pin), .config_load_pin(config_load_pin),
        .io_update(io_update), .nv_port_cfg(8'h81), .nv_readback_sel(8'h01),
        .nv_tag_low(8'h34), .nv_tag_high(8'h12), .host_reading(host_reading),
        .four_wire_select(four_wire_select), .lsb_first(lsb_first),
        .addr_increment(addr_increment), .read_from_active(read_from_active),
        .bidir_read_oe(bidir_read_oe), .serial_read_out_pin_oe(serial_read_out_pin_oe),
        .reload_from_nv(reload_from_nv), .reload_from_defaults(reload_from_defaults),
        .user_tag(user_tag));

    // closing report
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s: saw %h, expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic chk1(input logic seen, input logic exp, input string what);
        check({15'h0000, seen}, {15'h0000, exp}, what);
    endtask

    task automatic rd_chk(input logic [11:0] addr, input logic [7:0] exp, input string what);
        logic [7:0] d;
        logic ack;
        hm.read_byte(addr, d, ack);
        check({8'h00, d}, {8'h00, exp}, what);
        chk1(ack, 1'b1, "read answer");
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge clk);
    endtask

    // hang guard, well above the roughly 120 cycles the tests need
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            give_verdict();
        end
    end

    // main sequence
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        cycles(5);
        rd_chk(OFS_PORT_CFG, 8'h00, "cfg reset");
        rd_chk(OFS_READBACK_SEL, 8'h00, "readback reset");
        rd_chk(OFS_TAG_LOW, RST_TAG, "tag low reset");
        rd_chk(OFS_TAG_HIGH, RST_TAG, "tag high reset");
        // read-only, unmapped and unused places
        hm.write_byte(OFS_VARIANT_ID, 8'hFF);
        rd_chk(OFS_VARIANT_ID, VID, "variant id");
        hm.write_byte(12'h001, 8'hFF);
        rd_chk(12'h001, READ_ZERO, "unmapped");
        hm.write_byte(OFS_READBACK_SEL, 8'hFE);
        rd_chk(OFS_READBACK_SEL, 8'h00, "sel unused");
        hm.write_byte(OFS_PORT_CFG, 8'h10);
        rd_chk(OFS_PORT_CFG, 8'h00, "cfg bit4");
        // every mode and order combination, with both read directions
        for (int m = 0; m < 4; m++) begin
            hm.write_byte(OFS_PORT_CFG, {m[1:0], 6'h00});
            host_reading = 1'b1;
            cycles(1);
            chk1(four_wire_select, m[1], "four wire");
            chk1(serial_read_out_pin_oe, m[1], "read pin oe");
            chk1(bidir_read_oe, ~m[1], "bidir oe");
            chk1(lsb_first, m[0], "lsb first");
            chk1(addr_increment, m[0], "addr incr");
            host_reading = 1'b0;
            cycles(1);
            chk1(serial_read_out_pin_oe | bidir_read_oe, 1'b0, "oe idle");
            rd_chk(OFS_PORT_CFG, {m[1], m[0], 4'h0, m[0], m[1]}, "cfg mirror");
        end
        // buffered and active tag copies
        hm.write_byte(OFS_TAG_LOW, 8'hA5);
        hm.write_byte(OFS_TAG_HIGH, 8'h5C);
        rd_chk(OFS_TAG_LOW, 8'hA5, "buffered low");
        check(user_tag, 16'h0000, "active before update");
        hm.write_byte(OFS_READBACK_SEL, 8'h01);
        rd_chk(OFS_TAG_HIGH, 8'h00, "active high");
        io_update = 1'b1;
        cycles(1);
        io_update = 1'b0;
        cycles(1);
        check(user_tag, 16'h5CA5, "tag after update");
        rd_chk(OFS_TAG_HIGH, 8'h5C, "active high updated");
        chk1(four_wire_select, 1'b1, "tag no effect");
        // mode bits unused under the second port protocol
        hm.write_byte(OFS_PORT_CFG, 8'h00);
        i2c_mode_pin = 1'b1;
        cycles(6);
        hm.write_byte(OFS_PORT_CFG, 8'hC0);
        cycles(1);
        chk1(four_wire_select | lsb_first, 1'b0, "i2c mode bits");
        rd_chk(OFS_PORT_CFG, 8'h00, "i2c cfg read");
        // soft reset to defaults, still honoured here
        hm.write_byte(OFS_PORT_CFG, 8'h20);
        cycles(1);
        chk1(reload_from_defaults, 1'b1, "default reload");
        chk1(reload_from_nv, 1'b0, "no storage reload");
        check(user_tag, {RST_TAG, RST_TAG}, "tag defaults");
        rd_chk(OFS_READBACK_SEL, 8'h00, "sel defaults");
        rd_chk(OFS_PORT_CFG, 8'h00, "bit5 self clear");
        i2c_mode_pin = 1'b0;
        cycles(6);
        chk1(four_wire_select, 1'b0, "discarded bits");
        // soft reset from the stored image
        config_load_pin = 1'b1;
        cycles(6);
        hm.write_byte(OFS_PORT_CFG, 8'h20);
        cycles(1);
        chk1(reload_from_nv, 1'b1, "storage reload");
        chk1(reload_from_defaults, 1'b0, "no default reload");
        check(user_tag, 16'h1234, "tag from storage");
        chk1(read_from_active, 1'b1, "sel from storage");
        rd_chk(OFS_PORT_CFG, 8'h81, "cfg from storage");
        rd_chk(OFS_TAG_LOW, 8'h34, "tag low from storage");
        give_verdict();
    end
endmodule
